/* dv/drs_nvm_model.sv */
// Behavioural memory that answers the sequencer's load requests
`timescale 1ns/100ps
`default_nettype none

module drs_nvm_model (
  input  wire logic              ref_clk_in,
  input  wire logic              req_in,
  input  wire logic [1:0]        addr_in,
  input  wire drs_pkg::drs_cfg_t mem_in,
  input  wire logic [1:0]        lat_in,
  output logic                   ack_out,
  output logic [7:0]             data_out
);
  int wait_q = 0;

  initial begin
    ack_out = 1'b0;
    data_out = 8'h00;
  end

  // Data is inverted once the ack cycle ends, so stale bytes never pass as valid
  always @(posedge ref_clk_in) begin
    #1;
    if (ack_out) begin
      ack_out = 1'b0;
      data_out = ~data_out;
      wait_q = 0;
    end else if (req_in && wait_q >= lat_in) begin
      ack_out = 1'b1;
      data_out = mem_in[8*(3-addr_in) +: 8];
    end else if (req_in) begin
      wait_q++;
    end
  end
endmodule

`default_nettype wire

/* dv/drs_reset_seq_chk.sv */
// Port assertions of the display reset sequencer
`timescale 1ns/100ps
`default_nettype none

module drs_reset_seq_chk #(
  parameter int unsigned SPIKE_CYC          = 8,
  parameter int unsigned CMD_WAIT_CYC       = 200,
  parameter int unsigned SLEEP_OUT_WAIT_CYC = 400
) (
  input wire logic                       ref_clk_in,
  input wire logic                       srst_in,
  input wire logic                       hw_reset_n_in,
  input wire logic                       cmd_valid_in,
  input wire logic                       cmd_sleep_out_in,
  input wire logic                       cmd_ready_out,
  input wire logic                       nvm_req_out,
  input wire logic [drs_pkg::NVM_AW-1:0] nvm_addr_out,
  input wire logic                       nvm_ack_in,
  input wire logic [drs_pkg::NVM_DW-1:0] nvm_data_in,
  input wire drs_pkg::drs_cfg_t          cfg_out,
  input wire logic                       cfg_valid_out,
  input wire logic                       in_reset_out,
  input wire logic                       display_blank_out,
  input wire logic                       awake_out
);
  localparam int BLK_LIM = 60;
  int unsigned low_q;
  int unsigned run_q;
  int unsigned rel_q;

  // Pin low counts, kept because the filtered edge may land after the pin rose
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      low_q <= 0;
      run_q <= 0;
      rel_q <= 0;
    end else begin
      low_q <= hw_reset_n_in ? 0 : low_q + 1;
      run_q <= (hw_reset_n_in && low_q != 0) ? low_q : run_q;
      rel_q <= (!hw_reset_n_in && in_reset_out) ? 0 : rel_q + 1;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  spike_reject_a: assert property (
    $rose(in_reset_out) |-> low_q >= SPIKE_CYC || run_q >= SPIKE_CYC)
    else $error("reset from short pulse");
  full_reset_a: assert property (
    low_q >= SPIKE_CYC + 6 |-> in_reset_out)
    else $error("long pulse not reset");
  glitch_hold_a: assert property (
    $rose(nvm_req_out) |-> rel_q >= SPIKE_CYC)
    else $error("load after glitch");
  addr_step_a: assert property (
    nvm_req_out && nvm_ack_in && nvm_addr_out != 2'h3
    |=> nvm_addr_out == 2'($past(nvm_addr_out) + 2'h1))
    else $error("address order");
  load_done_a: assert property (
    nvm_req_out && nvm_ack_in && nvm_addr_out == 2'h3
    |=> !nvm_req_out && cfg_valid_out && cfg_out[7:0] == $past(nvm_data_in))
    else $error("load end");
  reset_blank_a: assert property (
    $rose(in_reset_out) |-> display_blank_out && !cmd_ready_out && !cfg_valid_out)
    else $error("reset entry");
  blank_end_a: assert property (
    $rose(in_reset_out) && awake_out |-> ##[1:BLK_LIM] !awake_out)
    else $error("blanking too long");
  cmd_gate_a: assert property (
    cmd_ready_out |-> rel_q >= CMD_WAIT_CYC)
    else $error("command too early");
  sleep_gate_a: assert property (
    cmd_ready_out && cmd_sleep_out_in |-> rel_q >= SLEEP_OUT_WAIT_CYC)
    else $error("wake too early");
  wake_a: assert property (
    cmd_valid_in && cmd_ready_out && cmd_sleep_out_in
    |=> awake_out && !display_blank_out)
    else $error("wake not taken");

  cover property ($rose(in_reset_out) && awake_out);
  cover property (nvm_ack_in && nvm_addr_out == 2'h3);
  cover property (cmd_valid_in && cmd_ready_out && cmd_sleep_out_in);
endmodule

bind drs_reset_seq drs_reset_seq_chk #(.SPIKE_CYC(SPIKE_CYC), .CMD_WAIT_CYC(CMD_WAIT_CYC),
  .SLEEP_OUT_WAIT_CYC(SLEEP_OUT_WAIT_CYC)) u_drs_reset_seq_chk (.ref_clk_in, .srst_in,
  .hw_reset_n_in, .cmd_valid_in, .cmd_sleep_out_in, .cmd_ready_out, .nvm_req_out,
  .nvm_addr_out, .nvm_ack_in, .nvm_data_in, .cfg_out, .cfg_valid_out, .in_reset_out,
  .display_blank_out, .awake_out);

`default_nettype wire

/* dv/drs_reset_seq_tb_top.sv */
// Self-checking bench of the display reset sequencer
`timescale 1ns/100ps
`default_nettype none

module drs_reset_seq_tb_top;
  localparam int SP = 8;
  localparam int CW = 200;
  localparam int SW = 400;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic pin = 1'b1;
  logic cv = 1'b0;
  logic cso = 1'b0;
  logic csi = 1'b0;
  logic req, ack, ready, cval, inr, blank, awake;
  logic [1:0] addr;
  logic [1:0] lat = 2'h0;
  logic [7:0] data;
  drs_pkg::drs_cfg_t cfg;
  drs_pkg::drs_cfg_t mem = 32'h0000_0000;
  drs_pkg::drs_cfg_t exp_q[$];
  logic [31:0] rng = 32'hBA1F48E8;
  int fails = 0;
  int n_compared = 0;
  realtime rel_t;

  initial forever #5 ref_clk_in = ~ref_clk_in;

  drs_reset_seq #(.SPIKE_CYC(SP), .CMD_WAIT_CYC(CW), .SLEEP_OUT_WAIT_CYC(SW), .BLANK_CYC(50))
    u_drs_reset_seq (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .hw_reset_n_in(pin),
    .cmd_valid_in(cv), .cmd_sleep_out_in(cso), .cmd_sleep_in_in(csi),
    .cmd_ready_out(ready), .nvm_req_out(req), .nvm_addr_out(addr), .nvm_ack_in(ack),
    .nvm_data_in(data), .cfg_out(cfg), .cfg_valid_out(cval), .in_reset_out(inr),
    .display_blank_out(blank), .awake_out(awake));
  drs_nvm_model u_drs_nvm_model (.ref_clk_in(ref_clk_in), .req_in(req), .addr_in(addr),
    .mem_in(mem), .lat_in(lat), .ack_out(ack), .data_out(data));

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic int since();
    return int'(($realtime - rel_t) / 10.0);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic miss(input string m);
    fails++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_cfg();
    n_compared++;
    if (cfg !== exp_q.pop_front()) miss("loaded settings");
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string m);
    n_compared++;
    if (got !== exp) miss(m);
  endtask
  task automatic cmp_time(input int t, input int lo, input int hi, input string m);
    n_compared++;
    if (t < lo || t > hi) miss(m);
  endtask
  // Bounded wait: 0 for load done, 1 for command ready
  task automatic wait_on(input int k);
    for (int c = 0; c < 3000; c++) begin
      if (k == 0 ? cval === 1'b1 : ready === 1'b1) return;
      tick(1);
    end
    miss("wait timed out");
    end_of_test();
  endtask
  task automatic pulse(input int lo);
    pin = 1'b0;
    tick(lo);
    pin = 1'b1;
    rel_t = $realtime;
  endtask
  task automatic reload();
    wait_on(0);
    cmp_cfg();
    cmp_bit(awake, 1'b0, "still awake after reset");
  endtask

  initial begin
    mem = xs();
    exp_q.push_back(mem);
    tick(5);
    srst_in = 1'b0;
    rel_t = $realtime;
    reload();
    cmp_time(since(), 0, CW, "load late");
    cv = 1'b1;
    wait_on(1);
    cmp_time(since(), CW, CW + SP + 8, "command gate");
    tick(1);
    cso = 1'b1;
    // Ready is combinational, let it settle first
    #1;
    cmp_bit(ready, 1'b0, "early wake accepted");
    wait_on(1);
    cmp_time(since(), SW, SW + SP + 8, "wake gate");
    tick(1);
    cso = 1'b0;
    csi = 1'b1;
    cmp_bit(awake & ~blank, 1'b1, "wake not applied");
    tick(1);
    cv = 1'b0;
    csi = 1'b0;
    cmp_bit(awake | ~blank, 1'b0, "sleep not applied");
    tick(1);
    cv = 1'b1;
    cso = 1'b1;
    tick(1);
    cv = 1'b0;
    cso = 1'b0;
    cmp_bit(awake & ~blank, 1'b1, "second wake not applied");
    $display("test wake done");
    pulse(SP - 3);
    tick(20);
    cmp_bit(inr | ~ready, 1'b0, "spike reset");
    $display("test spike done");
    mem = xs();
    lat = rng[1:0];
    exp_q.push_back(mem);
    pulse(14 + int'(rng[3:0]));
    cmp_bit(inr & blank, 1'b1, "no blanking");
    reload();
    cmp_time(since(), 0, SW, "awake reset late");
    $display("test awake reset done");
    mem = xs();
    lat = rng[1:0];
    exp_q.push_back(mem);
    pulse(20);
    tick(SP / 2);
    pulse(20);
    reload();
    cmp_time(since(), 0, CW, "sleep reset late");
    $display("test glitch reset done");
    end_of_test();
  end
endmodule

`default_nettype wire

/* verilog/drs_pkg.sv */
// Shared constants, timing counts and types of the display reset sequencer
`default_nettype none

package drs_pkg;

  // ***************************************************************
  // Clock and timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned SPIKE_REJECT_NS   = 5000;
  localparam int unsigned FULL_RESET_NS     = 9000;
  localparam int unsigned SPIKE_CYC         =
    (SPIKE_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CMD_WAIT_US       = 5000;
  localparam int unsigned CMD_WAIT_CYC      =
    (CMD_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_OUT_WAIT_US = 120000;
  localparam int unsigned SLEEP_OUT_WAIT_CYC =
    (SLEEP_OUT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_MAX_US      = 120000;
  localparam int unsigned BLANK_US          = 50000;
  localparam int unsigned BLANK_CYC         = BLANK_US * 1000 / CLK_PERIOD_NS;

  // ***************************************************************
  // Widths, layout and reset values
  // ***************************************************************
  localparam int unsigned FILT_CNT_W = 12;
  localparam int unsigned CNT_W      = 24;
  localparam int unsigned NVM_AW     = 2;
  localparam int unsigned NVM_DW     = 8;
  localparam logic [NVM_AW-1:0] NVM_ADDR_ID0  = 2'h0;
  localparam logic [NVM_AW-1:0] NVM_ADDR_ID1  = 2'h1;
  localparam logic [NVM_AW-1:0] NVM_ADDR_ID2  = 2'h2;
  localparam logic [NVM_AW-1:0] NVM_ADDR_COMMON_VOLTAGE_SETTING = 2'h3;
  localparam logic [NVM_AW-1:0] NVM_ADDR_LAST = 2'h3;

  typedef struct packed {
    logic [NVM_DW-1:0] id0;
    logic [NVM_DW-1:0] id1;
    logic [NVM_DW-1:0] id2;
    logic [NVM_DW-1:0] common_voltage_setting;
  } drs_cfg_t;

  localparam drs_cfg_t CFG_DEFAULT = 32'h0000_0000;

  // Gray codes along blank -> hold -> load -> wait; wait -> run flips two bits
  typedef enum logic [2:0] {
    ST_RUN   = 3'h0,
    ST_BLANK = 3'h1,
    ST_HOLD  = 3'h3,
    ST_LOAD  = 3'h2,
    ST_WAIT  = 3'h6
  } drs_state_t;

  typedef struct packed {
    logic [2:0]            sync;
    logic                  level;
    logic                  rise;
    logic                  fall;
    logic [FILT_CNT_W-1:0] cnt;
  } drs_filt_t;

  typedef struct packed {
    drs_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic [CNT_W-1:0]  elapsed;
    logic              cmd_ok;
    logic              sleep_ok;
    logic              awake;
    logic              blank;
    drs_cfg_t          cfg;
    logic              cfg_valid;
    logic              nvm_req;
    logic [NVM_AW-1:0] nvm_addr;
  } drs_core_t;

endpackage

`default_nettype wire

/* verilog/drs_reset_seq.sv */
// Hardware reset sequencer of the display controller
`timescale 1ns/100ps
`default_nettype none

module drs_reset_seq #(
  parameter int unsigned SPIKE_CYC          = drs_pkg::SPIKE_CYC,
  parameter int unsigned CMD_WAIT_CYC       = drs_pkg::CMD_WAIT_CYC,
  parameter int unsigned SLEEP_OUT_WAIT_CYC = drs_pkg::SLEEP_OUT_WAIT_CYC,
  parameter int unsigned BLANK_CYC          = drs_pkg::BLANK_CYC
) (
  input  wire logic                          ref_clk_in,
  input  wire logic                          srst_in,
  input  wire logic                          hw_reset_n_in,
  input  wire logic                          cmd_valid_in,
  input  wire logic                          cmd_sleep_out_in,
  input  wire logic                          cmd_sleep_in_in,
  output logic                               cmd_ready_out,
  output logic                               nvm_req_out,
  output logic [drs_pkg::NVM_AW-1:0]         nvm_addr_out,
  input  wire logic                          nvm_ack_in,
  input  wire logic [drs_pkg::NVM_DW-1:0]    nvm_data_in,
  output var drs_pkg::drs_cfg_t              cfg_out,
  output logic                               cfg_valid_out,
  output logic                               in_reset_out,
  output logic                               display_blank_out,
  output logic                               awake_out
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************
  localparam int unsigned CNT_MAX = (1 << drs_pkg::CNT_W) - 1;

  generate
    if (CMD_WAIT_CYC < 1 || CMD_WAIT_CYC > CNT_MAX) begin : g_bad_cmd
      $error("CMD_WAIT_CYC out of range");
    end
    if (SLEEP_OUT_WAIT_CYC < CMD_WAIT_CYC || SLEEP_OUT_WAIT_CYC > CNT_MAX)
    begin : g_bad_sleep
      $error("SLEEP_OUT_WAIT_CYC out of range");
    end
    if (BLANK_CYC < 1 || BLANK_CYC > CNT_MAX) begin : g_bad_blank
      $error("BLANK_CYC out of range");
    end
    if (SPIKE_CYC * drs_pkg::CLK_PERIOD_NS > drs_pkg::FULL_RESET_NS)
    begin : g_bad_spike
      $error("SPIKE_CYC too long to catch a full reset pulse");
    end
  endgenerate

  localparam logic [drs_pkg::CNT_W-1:0] CMD_LAST   =
    drs_pkg::CNT_W'(CMD_WAIT_CYC - 1);
  localparam logic [drs_pkg::CNT_W-1:0] SLEEP_LAST =
    drs_pkg::CNT_W'(SLEEP_OUT_WAIT_CYC - 1);
  localparam logic [drs_pkg::CNT_W-1:0] BLANK_LAST =
    drs_pkg::CNT_W'(BLANK_CYC - 1);

  // ***************************************************************
  // Reset pin filtering
  // ***************************************************************
  logic pin_high;
  logic pin_rise;
  logic pin_fall;

  drs_spike_filter #(
    .HOLD_CYC (SPIKE_CYC)
  ) u_filter (
    .ref_clk_in (ref_clk_in),
    .srst_in    (srst_in),
    .pin_in     (hw_reset_n_in),
    .level_out  (pin_high),
    .rise_out   (pin_rise),
    .fall_out   (pin_fall)
  );

  // ***************************************************************
  // Sequencer state
  // ***************************************************************
  localparam drs_pkg::drs_core_t CORE_RESET = '{
    st:        drs_pkg::ST_HOLD,
    cnt:       '0,
    elapsed:   '0,
    cmd_ok:    1'b0,
    sleep_ok:  1'b0,
    awake:     1'b0,
    blank:     1'b1,
    cfg:       drs_pkg::CFG_DEFAULT,
    cfg_valid: 1'b0,
    nvm_req:   1'b0,
    nvm_addr:  '0
  };

  drs_pkg::drs_core_t q;
  drs_pkg::drs_core_t d;
  logic               cmd_take;

  // Exit-sleep stays refused until its own, longer wait has run out
  assign cmd_ready_out = q.cmd_ok && (!cmd_sleep_out_in || q.sleep_ok);
  assign cmd_take      = cmd_valid_in && cmd_ready_out;

  always_comb begin
    d = q;

    // Time since the last filtered release, saturating at the exit-sleep wait
    if (pin_rise) begin
      d.elapsed  = '0;
      d.sleep_ok = 1'b0;
    end else if (pin_high && q.elapsed != SLEEP_LAST) begin
      d.elapsed = q.elapsed + 1'b1;
    end else if (pin_high) begin
      d.sleep_ok = 1'b1;
    end

    unique case (q.st)
      drs_pkg::ST_BLANK: begin
        // Blanking runs to its end even if the pin is released meanwhile
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == BLANK_LAST) begin
          d.st    = drs_pkg::ST_HOLD;
          d.awake = 1'b0;
          d.cnt   = '0;
        end
      end
      drs_pkg::ST_HOLD: begin
        d.cfg = drs_pkg::CFG_DEFAULT;
        if (pin_high) begin
          d.st       = drs_pkg::ST_LOAD;
          d.nvm_req  = 1'b1;
          d.nvm_addr = drs_pkg::NVM_ADDR_ID0;
        end
      end
      drs_pkg::ST_LOAD: begin
        if (nvm_ack_in) begin
          unique case (q.nvm_addr)
            drs_pkg::NVM_ADDR_ID0: d.cfg.id0 = nvm_data_in;
            drs_pkg::NVM_ADDR_ID1: d.cfg.id1 = nvm_data_in;
            drs_pkg::NVM_ADDR_ID2: d.cfg.id2 = nvm_data_in;
            drs_pkg::NVM_ADDR_COMMON_VOLTAGE_SETTING: d.cfg.common_voltage_setting = nvm_data_in;
          endcase
          d.nvm_addr = q.nvm_addr + 1'b1;
        end
        // A stalled memory is cut off when elapsed hits 5ms; a load begun after that is never cut off
        if ((nvm_ack_in && q.nvm_addr == drs_pkg::NVM_ADDR_LAST) ||
            q.elapsed == CMD_LAST) begin
          d.st        = drs_pkg::ST_WAIT;
          d.nvm_req   = 1'b0;
          d.nvm_addr  = '0;
          d.cfg_valid = 1'b1;
        end
      end
      drs_pkg::ST_WAIT: begin
        if (q.elapsed >= CMD_LAST) begin
          d.st     = drs_pkg::ST_RUN;
          d.cmd_ok = 1'b1;
        end
      end
      drs_pkg::ST_RUN: begin
        if (cmd_take && cmd_sleep_out_in) begin
          d.awake = 1'b1;
          d.blank = 1'b0;
        end else if (cmd_take && cmd_sleep_in_in) begin
          d.awake = 1'b0;
          d.blank = 1'b1;
        end
      end
    endcase

    // A filtered fall wins over state, ready flags, load and blank in any state; awake, cfg and elapsed keep their computed values
    if (pin_fall) begin
      d.cmd_ok    = 1'b0;
      d.sleep_ok  = 1'b0;
      d.cfg_valid = 1'b0;
      d.nvm_req   = 1'b0;
      d.nvm_addr  = '0;
      d.blank     = 1'b1;
      d.cnt       = '0;
      if (q.awake) begin
        d.st = drs_pkg::ST_BLANK;
      end else begin
        d.st = drs_pkg::ST_HOLD;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      q <= CORE_RESET;
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign nvm_req_out       = q.nvm_req;
  assign nvm_addr_out      = q.nvm_addr;
  assign cfg_out           = q.cfg;
  assign cfg_valid_out     = q.cfg_valid;
  assign in_reset_out      = (q.st != drs_pkg::ST_RUN);
  assign display_blank_out = q.blank;
  assign awake_out         = q.awake;

endmodule

`default_nettype wire

/* verilog/drs_spike_filter.sv */
// Synchroniser and symmetric spike filter for the hardware reset pin
`timescale 1ns/100ps
`default_nettype none

module drs_spike_filter #(
  parameter int unsigned HOLD_CYC = drs_pkg::SPIKE_CYC
) (
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  // ***************************************************************
  // Parameter check
  // ***************************************************************
  generate
    if (HOLD_CYC < 1 || HOLD_CYC >= (1 << drs_pkg::FILT_CNT_W)) begin : g_bad
      $error("HOLD_CYC out of range");
    end
  endgenerate

  localparam logic [drs_pkg::FILT_CNT_W-1:0] LAST =
    drs_pkg::FILT_CNT_W'(HOLD_CYC - 1);

  drs_pkg::drs_filt_t q;
  drs_pkg::drs_filt_t d;

  // ***************************************************************
  // Filter
  // ***************************************************************
  always_comb begin
    d      = q;
    d.sync = {q.sync[1:0], pin_in};
    d.rise = 1'b0;
    d.fall = 1'b0;
    // Stage two and three must agree and differ from the filtered level
    if (q.sync[1] == q.sync[2] && q.sync[2] != q.level) begin
      if (q.cnt == LAST) begin
        d.level = q.sync[2];
        d.rise  = q.sync[2];
        d.fall  = ~q.sync[2];
        d.cnt   = '0;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end else begin
      // Any return to the held level restarts the count
      d.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level_out = q.level;
  assign rise_out  = q.rise;
  assign fall_out  = q.fall;

endmodule

`default_nettype wire
